// *** design/nvm_opt_cfg.svh ***
// Offsets, field positions, reset values and address windows of the option block
`ifndef NVM_OPT_CFG_SVH
`define NVM_OPT_CFG_SVH

// Register port offsets
`define NVM_OFS_OPTION     3'h0
`define NVM_OFS_CONFIG     3'h1
`define NVM_OFS_PROTECT    3'h2
`define NVM_OFS_STATUS     3'h3

// Option register fields
`define NVM_OPT_BACKDOOR_ENABLE_BIT  7
`define NVM_OPT_NORED_BIT  6
`define NVM_OPT_LAYOUT_BIT 5
`define NVM_OPT_USED_MASK  8'hE3
`define NVM_CODE_OPEN      2'h2

// Configuration register fields
`define NVM_CFG_PAGE_BIT   6
`define NVM_CFG_STEER_BIT  5
`define NVM_CFG_USED_MASK  8'h60

// Status register fields
`define NVM_STAT_VIOL_BIT  5

// Reset values; option and protect held until the nonvolatile copy lands, config held until written
`define NVM_OPT_RESET      8'h00
`define NVM_CFG_RESET      8'h00
`define NVM_PROT_RESET     8'hFF

// Protection fields and codes
`define NVM_EPS_NONE       2'h3
`define NVM_FPS_NONE       6'h3F
`define NVM_FPS_ALL        6'h18
`define NVM_FPS_STEP       16'h0600
`define NVM_EPS_STEP       16'h0010

// Address windows
`define NVM_KEY_LO         16'hFFB0
`define NVM_KEY_HI         16'hFFB7
`define NVM_EE_LO          16'h1400
`define NVM_EE_TOP         16'h1800
`define NVM_KEY_BYTES      4'h8

`endif

// *** design/nvm_opt_pkg.sv ***
// Types shared by the option and protection block
package nvm_opt_pkg;

    // Backdoor key collection states, Gray along the usual path
    typedef enum logic [1:0] {
        KEY_IDLE    = 2'b00,
        KEY_COLLECT = 2'b01,
        KEY_DONE    = 2'b11,
        KEY_FAIL    = 2'b10
    } key_state_e;

    // Nonvolatile command kinds
    typedef enum logic [1:0] {
        CMD_PROGRAM = 2'b00,
        CMD_SECTOR  = 2'b01,
        CMD_MASS    = 2'b10,
        CMD_BLANK   = 2'b11
    } cmd_kind_e;

endpackage

// *** design/nvm_guard_if.sv ***
// Carrier between the option block and its protection range checker
interface nvm_guard_if;
    logic [15:0] addr;
    logic [1:0]  eeprom_guard_select;
    logic [5:0]  flash_guard_select;
    logic        hit;
    logic        any_guarded;

    modport main  (output addr, eeprom_guard_select, flash_guard_select,
                   input hit, any_guarded);
    modport guard (input addr, eeprom_guard_select, flash_guard_select,
                   output hit, any_guarded);
endinterface

// *** design/nvm_guard_check.sv ***
// Protection range checker for flash and EEPROM addresses
`include "nvm_opt_cfg.svh"

module nvm_guard_check (
    // Range query
    nvm_guard_if.guard g
);

    //------------------------------------------------------------
    // Range decode
    //------------------------------------------------------------
    logic [5:0]  fps_eff;
    logic [5:0]  fps_steps;
    logic [15:0] flash_len;
    logic [15:0] flash_start;
    logic [15:0] ee_len;
    logic [15:0] ee_start;
    logic        in_eeprom;
    logic        ee_on;
    logic        flash_on;

    // Codes at or below the floor protect the whole array
    assign fps_eff     = (g.flash_guard_select < `NVM_FPS_ALL) ? `NVM_FPS_ALL
                                                               : g.flash_guard_select;
    assign fps_steps   = `NVM_FPS_NONE - fps_eff;
    assign flash_len   = 16'(fps_steps * `NVM_FPS_STEP);
    assign flash_start = (fps_eff == `NVM_FPS_ALL) ? 16'h0000 : 16'(16'h0000 - flash_len);
    assign flash_on    = (g.flash_guard_select != `NVM_FPS_NONE);

    // EEPROM protected span doubles with each lower code
    assign ee_len   = `NVM_EPS_STEP << (2'h2 - g.eeprom_guard_select);
    assign ee_start = `NVM_EE_TOP - ee_len;
    assign ee_on    = (g.eeprom_guard_select != `NVM_EPS_NONE);

    assign in_eeprom = (g.addr >= `NVM_EE_LO) && (g.addr < `NVM_EE_TOP);

    // Hit when the address falls in an enabled protected span
    assign g.hit = in_eeprom ? (ee_on && (g.addr >= ee_start))
                             : (flash_on && (g.addr >= flash_start));
    assign g.any_guarded = ee_on || flash_on;

endmodule

// *** design/nvm_option_security_protect.sv ***
// Option, configuration, security and block protection logic of the NVM controller
//
// Function
// - Reset copies stored option byte into option register
// - Backdoor disabled blocks key unlock
// - Key writes only from secured firmware
// - Ascending eight byte key match unlocks
// - Option bit 6 disables vector redirection
// - Option bit 5 picks EEPROM sector layout
// - Only code 1:0 means unsecured
// - Secure state blocks debug memory access
// - Key match or blank check sets 1:0
// - Config bit 6 picks visible EEPROM page
// - Config bit 5 steers key range writes
// - Reset loads protect register from storage
// - Non-debug protection writes may only grow region
// - Protected program or erase sets violation
// - Mass erase refused while anything protected
// - Debug host may rewrite protection freely
// - Bits 7:6 select EEPROM protection, 3 none
// - Bits 5:0 select flash protection, 3F none
// - Violation flag cleared by writing one
`include "nvm_opt_cfg.svh"

module nvm_option_security_protect (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_from_debug,
    output logic      [7:0]  reg_rdata,
    // Nonvolatile stored values
    input  wire logic [7:0]  stored_option_byte,
    input  wire logic [7:0]  stored_protect_byte,
    input  wire logic [63:0] stored_unlock_key,
    // Memory access from the bus
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_wr,
    input  wire logic        mem_rd,
    input  wire logic        mem_from_debug,
    output logic             mem_blocked,
    // Command requests and engine results
    input  wire logic        cmd_valid,
    input  wire logic [1:0]  cmd_kind,
    input  wire logic [15:0] cmd_addr,
    input  wire logic        blank_check_erased,
    output logic             cmd_launch,
    output logic      [1:0]  cmd_launch_kind,
    output logic      [15:0] cmd_launch_addr,
    output logic             cmd_refused,
    // Mode outputs
    output logic             secure,
    output logic             vector_redirect_disable,
    output logic             eeprom_sector_layout,
    output logic             eeprom_page_pick,
    output logic             loaded
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    logic [7:0]                   opt_r;
    logic [7:0]                   cfg_r;
    logic [7:0]                   prot_r;
    logic                         viol_r;
    logic                         load_pend_r;
    logic [7:0]                   rdata_r;
    logic [3:0]                   key_idx_r;
    nvm_opt_pkg::key_state_e      key_st_r;
    nvm_opt_pkg::key_state_e      key_st_nxt;
    logic                         launch_r;
    logic [1:0]                   launch_kind_r;
    logic [15:0]                  launch_addr_r;
    logic                         refused_r;

    nvm_guard_if guard_bus ();

    //------------------------------------------------------------
    // Field views
    //------------------------------------------------------------
    logic       backdoor_enable;
    logic [1:0] lock_state_code;
    logic       key_write_steer;
    logic [1:0] eeprom_guard_select;
    logic [5:0] flash_guard_select;

    assign backdoor_enable     = opt_r[`NVM_OPT_BACKDOOR_ENABLE_BIT];
    assign lock_state_code     = opt_r[1:0];
    assign key_write_steer     = cfg_r[`NVM_CFG_STEER_BIT];
    assign eeprom_guard_select = prot_r[7:6];
    assign flash_guard_select  = prot_r[5:0];

    // Security decode: only one code opens the part
    logic is_secure;
    assign is_secure = (lock_state_code != `NVM_CODE_OPEN);

    // Mode outputs from register bits; secure decoded from the lock code, loaded inverted
    assign secure                  = is_secure;
    assign vector_redirect_disable = opt_r[`NVM_OPT_NORED_BIT];
    assign eeprom_sector_layout    = opt_r[`NVM_OPT_LAYOUT_BIT];
    assign eeprom_page_pick        = cfg_r[`NVM_CFG_PAGE_BIT];
    assign loaded                  = !load_pend_r;

    // Debug source is locked out of memory while secure
    assign mem_blocked = is_secure && mem_from_debug && (mem_rd || mem_wr);

    //------------------------------------------------------------
    // Register port decode
    //------------------------------------------------------------
    logic wr_cfg;
    logic wr_prot;
    logic wr_stat;
    logic clr_viol;

    assign wr_cfg   = reg_wr && (reg_addr == `NVM_OFS_CONFIG);
    assign wr_prot  = reg_wr && (reg_addr == `NVM_OFS_PROTECT);
    assign wr_stat  = reg_wr && (reg_addr == `NVM_OFS_STATUS);
    assign clr_viol = wr_stat && reg_wdata[`NVM_STAT_VIOL_BIT];

    // Grow-only check: lower codes cover more memory
    logic [5:0] fps_new_eff;
    logic [5:0] fps_old_eff;
    logic       prot_grows;
    logic       prot_take;

    assign fps_new_eff = (reg_wdata[5:0] < `NVM_FPS_ALL) ? `NVM_FPS_ALL : reg_wdata[5:0];
    assign fps_old_eff = (flash_guard_select < `NVM_FPS_ALL) ? `NVM_FPS_ALL
                                                             : flash_guard_select;
    assign prot_grows  = (reg_wdata[7:6] <= eeprom_guard_select)
                      && (fps_new_eff <= fps_old_eff);
    assign prot_take   = wr_prot && (reg_from_debug || prot_grows);

    // Read mux, unused bits forced low
    logic [7:0] rd_mux;
    assign rd_mux = (reg_addr == `NVM_OFS_OPTION)  ? (opt_r & `NVM_OPT_USED_MASK) :
                    (reg_addr == `NVM_OFS_CONFIG)  ? (cfg_r & `NVM_CFG_USED_MASK) :
                    (reg_addr == `NVM_OFS_PROTECT) ? prot_r :
                    (reg_addr == `NVM_OFS_STATUS)  ? {2'h0, viol_r, 5'h00} :
                                                     8'h00;

    //------------------------------------------------------------
    // Backdoor key collection
    //------------------------------------------------------------
    logic       key_range;
    logic       key_wr;
    logic [2:0] key_off;
    logic       key_byte_ok;
    logic       key_ok_src;
    logic       steer_drop;
    logic       key_unlock;

    assign key_range   = (mem_addr >= `NVM_KEY_LO) && (mem_addr <= `NVM_KEY_HI);
    assign key_off     = mem_addr[2:0];
    // Debug writes and writes from an open part never count
    assign key_ok_src  = !mem_from_debug && is_secure && backdoor_enable;
    assign key_wr      = mem_wr && key_range && key_write_steer && key_ok_src;
    assign key_byte_ok = ({1'b0, key_off} == key_idx_r)
                      && (mem_wdata == stored_unlock_key[{key_off, 3'h0} +: 8]);
    assign steer_drop  = wr_cfg && key_write_steer && !reg_wdata[`NVM_CFG_STEER_BIT];
    // Clearing the steer bit after a full match opens the part
    assign key_unlock  = steer_drop && (key_st_r == nvm_opt_pkg::KEY_DONE)
                      && backdoor_enable;

    // Key state transitions
    always_comb begin
        key_st_nxt = key_st_r;
        unique case (key_st_r)
            nvm_opt_pkg::KEY_IDLE: begin
                if (key_wr) begin
                    key_st_nxt = key_byte_ok ? nvm_opt_pkg::KEY_COLLECT
                                             : nvm_opt_pkg::KEY_FAIL;
                end
            end
            nvm_opt_pkg::KEY_COLLECT: begin
                if (key_wr && !key_byte_ok) begin
                    key_st_nxt = nvm_opt_pkg::KEY_FAIL;
                end else if (key_wr && (key_idx_r == `NVM_KEY_BYTES - 4'h1)) begin
                    key_st_nxt = nvm_opt_pkg::KEY_DONE;
                end
            end
            nvm_opt_pkg::KEY_DONE: begin
                if (key_wr) begin
                    key_st_nxt = nvm_opt_pkg::KEY_FAIL;
                end
            end
            nvm_opt_pkg::KEY_FAIL: begin
                key_st_nxt = nvm_opt_pkg::KEY_FAIL;
            end
        endcase
        // Every drop of the steer bit ends the attempt
        if (steer_drop) begin
            key_st_nxt = nvm_opt_pkg::KEY_IDLE;
        end
    end

    // Key state and byte index
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            key_st_r  <= nvm_opt_pkg::KEY_IDLE;
            key_idx_r <= 4'h0;
        end else begin
            key_st_r <= key_st_nxt;
            if (steer_drop) begin
                key_idx_r <= 4'h0;
            end else if (key_wr) begin
                key_idx_r <= key_idx_r + 4'h1;
            end
        end
    end

    //------------------------------------------------------------
    // Command screening
    //------------------------------------------------------------
    logic        key_prog;
    logic        req_valid;
    logic [1:0]  req_kind;
    logic [15:0] req_addr;
    logic        req_modifies;
    logic        req_bad;

    // Key range writes with steer low start a program command
    assign key_prog  = mem_wr && key_range && !key_write_steer && !mem_blocked;
    assign req_valid = cmd_valid || key_prog;
    assign req_kind  = cmd_valid ? cmd_kind : nvm_opt_pkg::CMD_PROGRAM;
    assign req_addr  = cmd_valid ? cmd_addr : mem_addr;

    assign guard_bus.addr                = req_addr;
    assign guard_bus.eeprom_guard_select = eeprom_guard_select;
    assign guard_bus.flash_guard_select  = flash_guard_select;

    assign req_modifies = (req_kind == nvm_opt_pkg::CMD_PROGRAM)
                       || (req_kind == nvm_opt_pkg::CMD_SECTOR);
    assign req_bad = req_valid && !load_pend_r
                  && ((req_modifies && guard_bus.hit)
                   || ((req_kind == nvm_opt_pkg::CMD_MASS) && guard_bus.any_guarded));

    nvm_guard_check u_guard (
        .g (guard_bus.guard)
    );

    // Launch or refuse the screened request
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            launch_r      <= 1'b0;
            launch_kind_r <= 2'h0;
            launch_addr_r <= 16'h0000;
            refused_r     <= 1'b0;
        end else begin
            launch_r  <= req_valid && !load_pend_r && !req_bad;
            refused_r <= req_bad;
            if (req_valid) begin
                launch_kind_r <= req_kind;
                launch_addr_r <= req_addr;
            end
        end
    end

    assign cmd_launch      = launch_r;
    assign cmd_launch_kind = launch_kind_r;
    assign cmd_launch_addr = launch_addr_r;
    assign cmd_refused     = refused_r;

    //------------------------------------------------------------
    // Option register and nonvolatile load
    //------------------------------------------------------------
    logic open_evt;
    assign open_evt = key_unlock || blank_check_erased;

    // Option copy taken once after reset release
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            opt_r       <= `NVM_OPT_RESET;
            load_pend_r <= 1'b1;
        end else if (load_pend_r) begin
            opt_r       <= stored_option_byte & `NVM_OPT_USED_MASK;
            load_pend_r <= 1'b0;
        end else if (open_evt) begin
            opt_r[1:0]  <= `NVM_CODE_OPEN;
        end
    end

    //------------------------------------------------------------
    // Configuration register
    //------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_r <= `NVM_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= reg_wdata & `NVM_CFG_USED_MASK;
        end
    end

    //------------------------------------------------------------
    // Protection register
    //------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prot_r <= `NVM_PROT_RESET;
        end else if (load_pend_r) begin
            prot_r <= stored_protect_byte;
        end else if (prot_take) begin
            prot_r <= reg_wdata;
        end
    end

    //------------------------------------------------------------
    // Violation flag, set wins over clear
    //------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            viol_r <= 1'b0;
        end else if (req_bad) begin
            viol_r <= 1'b1;
        end else if (clr_viol) begin
            viol_r <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Read data, valid the cycle after the strobe
    //------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

// *** tb/nvm_opt_sva.sv ***
// Concurrent checks on the option and protection block ports
module nvm_opt_sva (
    // Clock, reset and register port
    input wire logic       clk_sys, reset, reg_wr, reg_rd,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    // Memory and command side
    input wire logic       mem_wr, mem_rd, mem_from_debug, mem_blocked,
    input wire logic       cmd_valid, blank_check_erased, cmd_launch, cmd_refused,
    input wire logic [1:0] cmd_kind, cmd_launch_kind,
    // Mode outputs
    input wire logic       secure, vector_redirect_disable, eeprom_sector_layout,
    input wire logic       eeprom_page_pick
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ---------------------------------
    // Register reads
    // ---------------------------------
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    opt_fields_a: assert property (
        reg_rd && reg_addr == 3'h0 && !$past(reset) |=> reg_rdata[4:2] == 3'h0
        && vector_redirect_disable == reg_rdata[6] && eeprom_sector_layout == reg_rdata[5])
        else $error("option fields disagree with mode outputs");
    lock_code_a: assert property (
        reg_rd && reg_addr == 3'h0 && !blank_check_erased && !$past(reset)
        |=> secure == (reg_rdata[1:0] != 2'h2))
        else $error("secure output disagrees with lock code");
    cfg_fields_a: assert property (
        reg_rd && reg_addr == 3'h1 |=> reg_rdata[7] == 1'b0 && reg_rdata[4:0] == 5'h00
        && eeprom_page_pick == reg_rdata[6])
        else $error("config fields disagree with page output");
    unmapped_read_a: assert property (reg_rd && reg_addr[2] |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    // ---------------------------------
    // Security and commands
    // ---------------------------------
    debug_block_a: assert property (
        mem_blocked == (secure && mem_from_debug && (mem_rd || mem_wr)))
        else $error("memory block decision wrong");
    unlock_hold_a: assert property (!secure |=> !secure)
        else $error("security came back before reset");
    blank_pass_a: assert property (
        cmd_valid && cmd_kind == nvm_opt_pkg::CMD_BLANK && !$past(reset)
        |=> cmd_launch && cmd_launch_kind == nvm_opt_pkg::CMD_BLANK)
        else $error("blank check not launched");
    launch_cause_a: assert property (cmd_launch |-> $past(cmd_valid) || $past(mem_wr))
        else $error("launch without request");
    refuse_cause_a: assert property (cmd_refused |-> !cmd_launch ##0
        ($past(cmd_valid) || $past(mem_wr)))
        else $error("refusal without request");

    // Main scenarios reached
    unlock_c: cover property ($fell(secure));
    refuse_c: cover property (cmd_refused);
    blank_c:  cover property (cmd_launch && cmd_launch_kind == nvm_opt_pkg::CMD_BLANK);
endmodule

// *** tb/nvm_store_model.sv ***
// Far-side model: stored nonvolatile bytes and a blank check engine
module nvm_store_model #(
    parameter logic [63:0] KEY = 64'h0
) (
    // Clock, reset and profile pick
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        profile,
    // Launches from the block
    input  wire logic        cmd_launch,
    input  wire logic [1:0]  cmd_launch_kind,
    // Stored values and engine result
    output logic      [7:0]  stored_option_byte,
    output logic      [7:0]  stored_protect_byte,
    output logic      [63:0] stored_unlock_key,
    output logic             blank_check_erased
);
    timeunit 1ns;
    timeprecision 1ps;

    // Stored contents; only the option byte varies per profile
    assign stored_option_byte  = profile ? 8'h1C : 8'hFD;
    assign stored_protect_byte = 8'hFF;
    assign stored_unlock_key   = KEY;

    // Erased array reported one cycle after a blank check launch
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            blank_check_erased <= 1'b0;
        end else begin
            blank_check_erased <= cmd_launch && cmd_launch_kind == nvm_opt_pkg::CMD_BLANK;
        end
    end
endmodule

// *** tb/nvm_option_security_protect_test.sv ***
// Self-checking bench for the option, security and protection block
module nvm_option_security_protect_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] KEY = 64'h5A3C_9E17_C2D4_6B81;

    // ---------------------------------
    // Signals
    // ---------------------------------
    logic        clk_sys = 1'b0, reset = 1'b1, prof = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00, mem_wdata = 8'h00, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_from_debug = 1'b0;
    logic [15:0] mem_addr = 16'h0000, cmd_addr = 16'h0000, cmd_launch_addr;
    logic        mem_wr = 1'b0, mem_rd = 1'b0, mem_from_debug = 1'b0, cmd_valid = 1'b0;
    logic [1:0]  cmd_kind = 2'h0, cmd_launch_kind;
    logic [7:0]  sopt, sprot;
    logic [63:0] skey;
    logic        erased, mem_blocked, cmd_launch, cmd_refused, secure;
    logic        vector_redirect_disable, eeprom_sector_layout, eeprom_page_pick, loaded;
    int          fails = 0, n_checks = 0;

    always #2 clk_sys = ~clk_sys;

    // Design and far-side model
    nvm_option_security_protect dut_u (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_from_debug(reg_from_debug), .reg_rdata(reg_rdata),
        .stored_option_byte(sopt), .stored_protect_byte(sprot), .stored_unlock_key(skey),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .mem_from_debug(mem_from_debug), .mem_blocked(mem_blocked),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
        .blank_check_erased(erased), .cmd_launch(cmd_launch),
        .cmd_launch_kind(cmd_launch_kind), .cmd_launch_addr(cmd_launch_addr),
        .cmd_refused(cmd_refused), .secure(secure),
        .vector_redirect_disable(vector_redirect_disable),
        .eeprom_sector_layout(eeprom_sector_layout),
        .eeprom_page_pick(eeprom_page_pick), .loaded(loaded));
    nvm_store_model #(.KEY(KEY)) store_u (.clk_sys(clk_sys), .reset(reset),
        .profile(prof), .cmd_launch(cmd_launch), .cmd_launch_kind(cmd_launch_kind),
        .stored_option_byte(sopt), .stored_protect_byte(sprot),
        .stored_unlock_key(skey), .blank_check_erased(erased));

    // ---------------------------------
    // Tasks
    // ---------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic p);
        @(posedge clk_sys);
        prof  <= p;
        reset <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk_sys);
        reg_addr       <= a;
        reg_wdata      <= d;
        reg_from_debug <= dbg;
        reg_wr         <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic mw(input logic [15:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk_sys);
        mem_addr       <= a;
        mem_wdata      <= d;
        mem_from_debug <= dbg;
        mem_wr         <= 1'b1;
        @(posedge clk_sys);
        mem_wr <= 1'b0;
        #1;
    endtask

    task automatic mp(input logic dbg, input logic exp);
        @(posedge clk_sys);
        mem_rd         <= 1'b1;
        mem_from_debug <= dbg;
        #1 chk({7'h0, mem_blocked}, {7'h0, exp});
        @(posedge clk_sys);
        mem_rd <= 1'b0;
    endtask

    task automatic cmd(input logic [1:0] k, input logic [15:0] a, input logic ok);
        @(posedge clk_sys);
        cmd_kind  <= k;
        cmd_addr  <= a;
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        #1 chk({6'h0, cmd_launch, cmd_refused}, {6'h0, ok, !ok});
    endtask

    // Full key entry, byte 3 spoiled by the flip mask
    task automatic key(input logic dbg, input logic [7:0] flip);
        wr(3'h1, 8'h20, 1'b0);
        for (int i = 0; i < 8; i++)
            mw(16'hFFB0 + 16'(i), KEY[8*i +: 8] ^ ((i == 3) ? flip : 8'h00), dbg);
        wr(3'h1, 8'h00, 1'b0);
        @(posedge clk_sys);
        #1;
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ---------------------------------
    // Sequence
    // ---------------------------------
    initial begin
        do_reset(1'b0);
        rd(3'h0, 8'hE1);
        chk({5'h0, secure, vector_redirect_disable, eeprom_sector_layout}, 8'h07);
        wr(3'h0, 8'h1E, 1'b0);
        rd(3'h0, 8'hE1);
        rd(3'h2, 8'hFF);
        rd(3'h5, 8'h00);
        wr(3'h1, 8'hFF, 1'b0);
        rd(3'h1, 8'h60);
        chk({7'h0, eeprom_page_pick}, 8'h01);
        wr(3'h1, 8'h00, 1'b0);
        mp(1'b1, 1'b1);
        mp(1'b0, 1'b0);
        wr(3'h2, 8'hBF, 1'b0);
        rd(3'h2, 8'hBF);
        wr(3'h2, 8'hFF, 1'b0);
        rd(3'h2, 8'hBF);
        wr(3'h2, 8'h7E, 1'b0);
        rd(3'h2, 8'h7E);
        cmd(nvm_opt_pkg::CMD_SECTOR, 16'h17E0, 1'b0);
        wr(3'h2, 8'hFE, 1'b1);
        rd(3'h2, 8'hFE);
        cmd(nvm_opt_pkg::CMD_PROGRAM, 16'hFB00, 1'b0);
        rd(3'h3, 8'h20);
        wr(3'h3, 8'h20, 1'b0);
        rd(3'h3, 8'h00);
        cmd(nvm_opt_pkg::CMD_PROGRAM, 16'h8000, 1'b1);
        cmd(nvm_opt_pkg::CMD_SECTOR, 16'hFA00, 1'b0);
        cmd(nvm_opt_pkg::CMD_MASS, 16'h0000, 1'b0);
        mw(16'hFFB0, 8'h00, 1'b0);
        chk({loaded, cmd_launch_addr[12:8], cmd_launch, cmd_refused}, 8'hFD);
        key(1'b1, 8'h00);
        chk({7'h0, secure}, 8'h01);
        key(1'b0, 8'h40);
        chk({7'h0, secure}, 8'h01);
        key(1'b0, 8'h00);
        chk({7'h0, secure}, 8'h00);
        rd(3'h0, 8'hE2);
        do_reset(1'b1);
        rd(3'h0, 8'h00);
        key(1'b0, 8'h00);
        chk({7'h0, secure}, 8'h01);
        cmd(nvm_opt_pkg::CMD_MASS, 16'h0000, 1'b1);
        cmd(nvm_opt_pkg::CMD_BLANK, 16'h0000, 1'b1);
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h0, secure}, 8'h00);
        tally_and_finish();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails = fails + 1;
        tally_and_finish();
    end
endmodule

bind nvm_option_security_protect nvm_opt_sva chk_u (.clk_sys(clk_sys), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_from_debug(mem_from_debug),
    .mem_blocked(mem_blocked), .cmd_valid(cmd_valid),
    .blank_check_erased(blank_check_erased), .cmd_launch(cmd_launch),
    .cmd_refused(cmd_refused), .cmd_kind(cmd_kind), .cmd_launch_kind(cmd_launch_kind),
    .secure(secure), .vector_redirect_disable(vector_redirect_disable),
    .eeprom_sector_layout(eeprom_sector_layout), .eeprom_page_pick(eeprom_page_pick));
